// ==== logic/gate_drv_host_pkg.sv ====
/*
  Shared constants and types for the controller that drives a half-bridge
  gate driver through its PWM, zero-cross and enable/fault pins.
  Assumes a single 40 MHz clock domain on the controller side.
*/
package gate_drv_host_pkg;

  // Controller clock rate in kHz.
  localparam int unsigned CLK_KHZ = 40000;

  // Highest switching frequency the driver accepts, in kHz.
  localparam int unsigned PWM_FMAX_KHZ = 1500;

  // Longest driver start-up time after enable or supply valid, in microseconds.
  localparam int unsigned STARTUP_US = 20;

  // Start-up wait in cycles, rounded up so the driver is surely ready.
  localparam int unsigned STARTUP_CYCLES = (STARTUP_US * CLK_KHZ + 999) / 1000;

  // Shortest PWM period in cycles, rounded up so the frequency stays below the limit.
  localparam int unsigned PWM_MIN_PERIOD_CYCLES = (CLK_KHZ + PWM_FMAX_KHZ - 1) / PWM_FMAX_KHZ;

  // Width of the start-up counter.
  localparam int unsigned CNT_W = 10;

  // Width of the PWM period and duty words.
  localparam int unsigned PWM_W = 8;

  // Controller sequencing states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_RUN,
    ST_FAULT
  } host_state_t;

  // Pin-side outputs toward the driver; every output enable is active low.
  typedef struct packed {
    logic pwm;            // PWM level while driven.
    logic pwm_oe_n;       // Low while the PWM pin is driven; high leaves it in 3-state.
    logic enable;         // Level driven on the enable/fault pin.
    logic enable_oe_n;    // Low while the enable/fault pin is driven.
    logic zero_cross;     // Level for the zero-cross input of the driver.
  } pin_out_t;

endpackage : gate_drv_host_pkg

// ==== logic/pwm_carrier.sv ====
/*
  Free-running PWM carrier: a period counter and a duty compare.
  Assumes period and duty come from logic on the same clock.
*/
`timescale 1ns/1ps
module pwm_carrier #(
  parameter int unsigned W = gate_drv_host_pkg::PWM_W
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Control.
  input  wire logic         run_i,
  input  wire logic [W-1:0] period_i,
  input  wire logic [W-1:0] duty_i,
  // Output.
  output logic              pwm_o
);

  // Shortest period as a word of the counter width.
  localparam logic [W-1:0] MIN_PER = W'(gate_drv_host_pkg::PWM_MIN_PERIOD_CYCLES);

  typedef struct packed {
    logic [W-1:0] cnt;     // Position in the current period.
    logic [W-1:0] per;     // Period held for the current cycle.
    logic [W-1:0] duty;    // Duty held for the current cycle.
    logic         pwm;     // Registered PWM level.
  } carrier_t;

  carrier_t s_reg;  // Registered state.
  carrier_t s_next; // Next state.

  // Period and duty are taken only at a period boundary, so a change never cuts a pulse short.
  always_comb begin
    s_next = s_reg;
    if (!run_i) begin
      s_next.cnt = '0;
      s_next.pwm = 1'b0;
      s_next.per = MIN_PER;
      s_next.duty = '0;
    end else begin
      if (s_reg.cnt >= s_reg.per - W'(1)) begin
        s_next.cnt = '0;
        // Periods shorter than the limit are stretched to it.
        s_next.per = (period_i < MIN_PER) ? MIN_PER : period_i;
        s_next.duty = duty_i;
      end else begin
        s_next.cnt = s_reg.cnt + W'(1);
      end
      s_next.pwm = (s_next.cnt < s_next.duty);
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_reg <= '{cnt: '0, per: MIN_PER, duty: '0, pwm: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pwm_o = s_reg.pwm;

endmodule : pwm_carrier

// ==== logic/gate_drv_host.sv ====
/*
  Controller that sequences and drives a half-bridge gate driver: it waits
  for the logic supply, raises enable, holds PWM in 3-state during start-up,
  then switches, and watches the enable/fault pin for a fault pull-down.
  Assumes the pins are resolved outside: supply_good_i and enable_i arrive
  asynchronously, the enable pin has a weak pull-down at the device.
*/
// How it works
// - No PWM before the logic supply.
// - PWM kept 3-state during start-up.
// - Controller drives enable high to start.
// - PWM frequency at most 1.5 MHz.
`timescale 1ns/1ps
module gate_drv_host #(
  parameter int unsigned PWM_W = gate_drv_host_pkg::PWM_W
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // User side.
  input  wire logic             run_i,          // Request switching.
  input  wire logic             shed_i,         // Park PWM in 3-state (phase shedding).
  input  wire logic             zero_cross_i,   // Zero-cross level to pass to the driver.
  input  wire logic [PWM_W-1:0] period_i,       // PWM period in cycles.
  input  wire logic [PWM_W-1:0] duty_i,         // PWM high time in cycles.
  output logic                  running_o,      // Start-up done, PWM switching.
  output logic                  fault_o,        // Driver reported a fault.
  output gate_drv_host_pkg::host_state_t state_o,
  // Device side.
  input  wire logic             supply_good_i,  // Logic supply of the driver is valid.
  input  wire logic             enable_i,       // Resolved level of the enable/fault pin.
  output gate_drv_host_pkg::pin_out_t pins_o
);

  localparam logic [gate_drv_host_pkg::CNT_W-1:0] START_LAST =
    (gate_drv_host_pkg::CNT_W)'(gate_drv_host_pkg::STARTUP_CYCLES - 1);

  typedef struct packed {
    gate_drv_host_pkg::host_state_t    st;      // Sequencing state.
    logic [gate_drv_host_pkg::CNT_W-1:0] cnt;   // Start-up wait counter.
    logic                              sup_s1;  // Supply-good first synchroniser stage.
    logic                              sup_s2;  // Supply-good second stage.
    logic                              en_s1;   // Enable pin first synchroniser stage.
    logic                              en_s2;   // Enable pin second stage.
    logic                              fault;   // Sticky fault flag.
    gate_drv_host_pkg::pin_out_t       pins;    // Registered pin drive.
  } host_t;

  host_t s_reg;  // Registered state.
  host_t s_next; // Next state.
  logic  pwm_w;  // Carrier output.

  // The carrier only runs while switching, so the first pulse starts clean after start-up.
  pwm_carrier #(
    .W        (PWM_W)
  ) u_carrier (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .run_i    (s_reg.st == gate_drv_host_pkg::ST_RUN),
    .period_i (period_i),
    .duty_i   (duty_i),
    .pwm_o    (pwm_w)
  );

  // Sequencing, fault watch and pin drive.
  always_comb begin
    s_next = s_reg;
    // Pin levels pass two flip-flops before any decision reads them.
    s_next.sup_s1 = supply_good_i;
    s_next.sup_s2 = s_reg.sup_s1;
    s_next.en_s1  = enable_i;
    s_next.en_s2  = s_reg.en_s1;
    unique case (s_reg.st)
      gate_drv_host_pkg::ST_IDLE: begin
        s_next.cnt = '0;
        // Start only once the supply is there, so no PWM precedes it.
        if (run_i && s_reg.sup_s2) begin
          s_next.st = gate_drv_host_pkg::ST_START;
        end
      end
      gate_drv_host_pkg::ST_START: begin
        // Wait out the driver's worst start-up time before switching.
        if (!run_i || !s_reg.sup_s2) begin
          s_next.st = gate_drv_host_pkg::ST_IDLE;
        end else if (s_reg.cnt == START_LAST) begin
          s_next.st = gate_drv_host_pkg::ST_RUN;
        end else begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
      end
      gate_drv_host_pkg::ST_RUN: begin
        if (!run_i || !s_reg.sup_s2) begin
          s_next.st = gate_drv_host_pkg::ST_IDLE;
        end else if (!s_reg.en_s2) begin
          // The device is pulling the pin low against us: a latched fault.
          s_next.st    = gate_drv_host_pkg::ST_FAULT;
          s_next.fault = 1'b1;
        end
      end
      gate_drv_host_pkg::ST_FAULT: begin
        // Only a supply drop (a device power-on reset) leaves ST_FAULT; the fault flag stays set until reset.
        if (!s_reg.sup_s2) begin
          s_next.st = gate_drv_host_pkg::ST_IDLE;
        end
      end
    endcase
    // Pin drive follows the next state so pins and state change on one edge.
    s_next.pins.enable      = 1'b1;
    // Drive enable high while starting or running; else release to the pull-down.
    s_next.pins.enable_oe_n = !(s_next.st == gate_drv_host_pkg::ST_START ||
                                s_next.st == gate_drv_host_pkg::ST_RUN);
    // PWM stays in 3-state except while running and not shed.
    s_next.pins.pwm_oe_n    = !(s_next.st == gate_drv_host_pkg::ST_RUN && !shed_i);
    s_next.pins.pwm         = (s_next.st == gate_drv_host_pkg::ST_RUN) ? pwm_w : 1'b0;
    // Zero-cross idles high, the level that leaves the low side to follow PWM.
    s_next.pins.zero_cross  = (s_next.st == gate_drv_host_pkg::ST_RUN) ? zero_cross_i : 1'b1;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_reg <= '{st: gate_drv_host_pkg::ST_IDLE, cnt: '0, sup_s1: 1'b0, sup_s2: 1'b0,
                 en_s1: 1'b0, en_s2: 1'b0, fault: 1'b0,
                 pins: '{pwm: 1'b0, pwm_oe_n: 1'b1, enable: 1'b1, enable_oe_n: 1'b1,
                         zero_cross: 1'b1}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins_o    = s_reg.pins;
  assign running_o = (s_reg.st == gate_drv_host_pkg::ST_RUN);
  assign fault_o   = s_reg.fault;
  assign state_o   = s_reg.st;

endmodule : gate_drv_host

// ==== test/gate_drv_host_checker.sv ====
/* Assertions on the controller's sequencing and pins.
   Assumes a bind to gate_drv_host with ports connected by name. */
`timescale 1ns/1ps
module gate_drv_host_checker (
  // Clock, reset and watched ports.
  input wire logic                          clk_i,
  input wire logic                          resetn_i,
  input wire logic                          enable_i,
  input wire logic                          supply_good_i,
  input wire logic                          running_o,
  input wire logic                          fault_o,
  input wire gate_drv_host_pkg::host_state_t state_o,
  input wire gate_drv_host_pkg::pin_out_t    pins_o
);
  logic [9:0] start_cnt_reg; // Cycles spent in start-up.
  logic [7:0] gap_reg;       // Cycles since the last PWM rise, saturating.
  logic       pwm_reg;       // PWM level one cycle ago, for edge finding.
  // Helper counters; the gap starts saturated so the first rise passes.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      start_cnt_reg <= 10'h000;
      gap_reg <= 8'hff;
      pwm_reg <= 1'b0;
    end else begin
      start_cnt_reg <= (state_o == gate_drv_host_pkg::ST_START) ?
                       start_cnt_reg + 10'h001 : 10'h000;
      gap_reg <= (pins_o.pwm && !pwm_reg) ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hff};
      pwm_reg <= pins_o.pwm;
    end
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_enter_start;
    state_o == gate_drv_host_pkg::ST_IDLE ##1 state_o == gate_drv_host_pkg::ST_START;
  endsequence
  sequence s_fault_seen;
    state_o == gate_drv_host_pkg::ST_RUN && !enable_i ##1 !enable_i ##1 !enable_i;
  endsequence
  property p_start_pins;
    s_enter_start |-> !pins_o.enable_oe_n && pins_o.enable && pins_o.pwm_oe_n;
  endproperty
  a_start_pins: assert property (p_start_pins) else $error("enable not driven at start");
  property p_start_tri;
    state_o == gate_drv_host_pkg::ST_START |-> pins_o.pwm_oe_n && !pins_o.pwm;
  endproperty
  a_start_tri: assert property (p_start_tri) else $error("pwm driven in start-up");
  property p_unpowered;
    !supply_good_i [*5] |-> pins_o.pwm_oe_n && !running_o;
  endproperty
  a_unpowered: assert property (p_unpowered) else $error("pwm without supply");
  property p_start_time;
    $rose(running_o) |-> start_cnt_reg >= 10'd800;
  endproperty
  a_start_time: assert property (p_start_time) else $error("start-up too short");
  property p_gap;
    pins_o.pwm && !pwm_reg |-> gap_reg >= 8'd26;
  endproperty
  a_gap: assert property (p_gap) else $error("pwm period too short");
  property p_fault;
    s_fault_seen |-> ##[0:2] fault_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not reported");
  property p_fault_hold;
    state_o == gate_drv_host_pkg::ST_FAULT |-> pins_o.enable_oe_n && pins_o.pwm_oe_n && fault_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("pins driven after fault");
endmodule : gate_drv_host_checker

// ==== test/gate_driver_model.sv ====
/* Behavioural half-bridge gate driver on the controller's pins.
   Assumes the controller clock paces its delays. */
`timescale 1ns/1ps
module gate_driver_model #(
  parameter int unsigned START_CYC = 800, // Start-up, 20 us at 40 MHz.
  parameter int unsigned HOLD_CYC  = 4    // Three-state hold-off in cycles.
) (
  // Clock and commands.
  input  wire logic                       clk_i,
  input  wire logic                       supply_i,
  input  wire logic                       fault_i,
  input  wire logic                       il_pos_i,
  // Controller pins.
  input  wire gate_drv_host_pkg::pin_out_t pins_i,
  // Resolved wire and gates.
  output logic                            enable_o,
  output logic                            high_side_gate_o,
  output logic                            low_side_gate_o,
  output logic                            negative_current_mode_o
);
  int unsigned start_cnt = 0; // Start-up progress.
  int unsigned hold_cnt  = 0; // Time spent in three-state.
  logic        latched   = 1'b0; // Fault latch, cleared only by supply loss.
  logic        on;
  logic [2:0]  boot_cnt  = 3'h0; // Forced low-side on-time left after a long 3-state.
  // Released wire reads low through the pull-down; a fault pull-down wins.
  assign enable_o = !latched && !pins_i.enable_oe_n && pins_i.enable;
  assign on = supply_i && enable_o && start_cnt >= START_CYC &&
              hold_cnt < HOLD_CYC;
  assign high_side_gate_o = on && pins_i.pwm && boot_cnt == 3'h0;
  // A long 3-state is taken as a drained bootstrap, so exit forces 100 ns of low side.
  assign low_side_gate_o = on && (boot_cnt != 3'h0 ||
                                  (!pins_i.pwm && pins_pwm_low_ok()));
  assign negative_current_mode_o = on && !pins_i.zero_cross && !il_pos_i;
  function automatic logic pins_pwm_low_ok();
    return pins_i.zero_cross || il_pos_i;
  endfunction : pins_pwm_low_ok
  // Start-up restarts whenever supply or enable drop.
  always @(posedge clk_i) begin
    if (!supply_i) latched <= 1'b0;
    else if (fault_i && start_cnt >= START_CYC) latched <= 1'b1;
    start_cnt <= (supply_i && enable_o) ? start_cnt + (start_cnt < START_CYC) : 0;
    hold_cnt <= pins_i.pwm_oe_n ? hold_cnt + (hold_cnt < HOLD_CYC) : 0;
    if (!pins_i.pwm_oe_n && hold_cnt >= HOLD_CYC) boot_cnt <= 3'h4;
    else if (boot_cnt != 3'h0) boot_cnt <= boot_cnt - 3'h1;
  end
endmodule : gate_driver_model

// ==== test/testbench.sv ====
/* Self-checking bench for gate_drv_host against a driver model.
   Assumes the 800-cycle start-up and 27-cycle PWM floor of the controller. */
`timescale 1ns/1ps
module testbench;
  logic clk, resetn, run, shed, zc, supply, fault;
  logic [7:0] period, duty;
  logic running_o, fault_o, enable;
  gate_drv_host_pkg::host_state_t state_o;
  gate_drv_host_pkg::pin_out_t    pins_o;
  int miscompares, total_checks, n, a, b;
  gate_drv_host u_dut (.clk_i(clk), .resetn_i(resetn), .run_i(run), .shed_i(shed),
    .zero_cross_i(zc), .period_i(period), .duty_i(duty), .running_o(running_o),
    .fault_o(fault_o), .state_o(state_o), .supply_good_i(supply), .enable_i(enable),
    .pins_o(pins_o));
  gate_driver_model u_drv (.clk_i(clk), .supply_i(supply), .fault_i(fault), .il_pos_i(1'b1),
    .pins_i(pins_o), .enable_o(enable), .high_side_gate_o(), .low_side_gate_o(),
    .negative_current_mode_o());
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : step
  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // Bounded polls; running out counts a mismatch, and a timed-out state wait also ends the run.
  task wait_state(input gate_drv_host_pkg::host_state_t s);
    n = 0;
    while (state_o !== s && n < 900) begin
      step(1);
      n++;
    end
    if (state_o !== s) begin
      miscompares++;
      $display("ERROR %0t state wait timed out", $time);
      finish_test();
    end
  endtask : wait_state
  task wait_pwm(input logic v, output int c);
    c = 0;
    while (pins_o.pwm !== v && c < 100) begin
      step(1);
      c++;
    end
    chk(pins_o.pwm === v, "pwm wait timed out");
  endtask : wait_pwm
  task t_power_order;
    run = 1'b1;
    step(10);
    chk(state_o === gate_drv_host_pkg::ST_IDLE && pins_o.pwm_oe_n === 1'b1,
        "start unpowered");
    supply = 1'b1;
    wait_state(gate_drv_host_pkg::ST_START);
    chk(pins_o.pwm_oe_n === 1'b1 && pins_o.enable_oe_n === 1'b0,
        "start pins");
    wait_state(gate_drv_host_pkg::ST_RUN);
    chk(n === 800 && running_o === 1'b1, "start-up wait");
    $display("t_power_order done");
  endtask : t_power_order
  task t_pwm_rate;
    wait_pwm(1'b0, a);
    wait_pwm(1'b1, a);
    wait_pwm(1'b0, a);
    wait_pwm(1'b1, b);
    chk(a + b === 27 && a === 5, "pwm period not clamped");
    zc = 1'b0;
    shed = 1'b1;
    step(3);
    chk(pins_o.zero_cross === 1'b0 && pins_o.pwm_oe_n === 1'b1,
        "shed or zero-cross");
    shed = 1'b0;
    step(3);
    chk(pins_o.pwm_oe_n === 1'b0, "shed release");
    $display("t_pwm_rate done");
  endtask : t_pwm_rate
  task t_fault;
    fault = 1'b1;
    step(1);
    fault = 1'b0;
    wait_state(gate_drv_host_pkg::ST_FAULT);
    chk(fault_o === 1'b1 && pins_o.enable_oe_n === 1'b1 && n < 6,
        "fault report");
    run = 1'b0;
    step(3);
    run = 1'b1;
    step(10);
    chk(state_o === gate_drv_host_pkg::ST_FAULT, "fault not latched");
    supply = 1'b0;
    wait_state(gate_drv_host_pkg::ST_IDLE);
    $display("t_fault done");
  endtask : t_fault
  initial begin
    {resetn, run, shed, supply, fault} = 5'h00;
    zc = 1'b1;
    period = 8'h0a;
    duty = 8'h05;
    miscompares = 0;
    total_checks = 0;
    step(5);
    resetn = 1'b1;
    t_power_order();
    t_pwm_rate();
    t_fault();
    finish_test();
  end
endmodule : testbench
bind gate_drv_host gate_drv_host_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .enable_i(enable_i), .supply_good_i(supply_good_i), .running_o(running_o),
  .fault_o(fault_o), .state_o(state_o), .pins_o(pins_o));
